/* File: design/csta_top.sv */
`timescale 1ns/1ps
module csta_top import csta_pkg::*; (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_b,
	// Semaphore writes from the two cores
	input wire csta_sem_req_t primary_core_sem,
	input wire csta_sem_req_t secondary_core_sem,
	// Micro-run requests from the two cores
	input wire logic primary_core_start,
	input wire logic secondary_core_start,
	// Configuration
	input wire logic [31:0] test_clock_divider_config,
	input wire logic [15:0] run_budget,
	// Scan engine result, valid with result_valid
	input wire logic result_valid,
	input wire csta_result_t result,
	// Trap request arriving from the system
	input wire logic ext_trap,
	// Semaphore and grant state
	output logic [1:0] sem_state,
	output logic primary_core_grant,
	output logic secondary_core_grant,
	// Run control
	output logic micro_busy,
	output logic primary_core_hold,
	output logic secondary_core_hold,
	output logic test_reset,
	output logic [15:0] reentry_addr,
	// Status and traps
	output logic [7:0] status,
	output logic primary_core_trap,
	output logic secondary_core_trap
);

	// Run sequencer states
	typedef enum logic [1:0] {
		IDLE,
		RUN,
		REENTER
	} csta_run_t;

	// Whole block state
	typedef struct packed {
		logic [1:0] sem;
		csta_run_t run;
		logic owner_sec;
		logic [15:0] cyc;
		logic [15:0] runs;
		logic [7:0] status;
		logic trap_p;
		logic trap_s;
		logic test_reset;
		logic [1:0] trap_sync;
		logic [15:0] reentry;
		// Registered copies of the decoded outputs
		logic grant_p;
		logic grant_s;
		logic busy;
		logic hold_p;
		logic hold_s;
	} csta_state_t;

	csta_state_t st;
	csta_state_t next_st;
	logic tick;

	// Divider for micro-run pacing
	csta_clk_div u_div (
		.mclk(mclk),
		.rst_b(rst_b),
		.div_sel(test_clock_divider_config[DIV_MSB:DIV_LSB]),
		.tick(tick)
	);

	// Primary may write unless secondary owns
	function automatic logic prim_may_write(input logic [1:0] s);
		return s != SEM_SECONDARY;
	endfunction

	// Secondary may write unless primary owns
	function automatic logic sec_may_write(input logic [1:0] s);
		return s != SEM_PRIMARY;
	endfunction

	// Resource access per core
	function automatic logic prim_access(input logic [1:0] s);
		return (s == SEM_RESET) || (s == SEM_PRIMARY);
	endfunction

	function automatic logic sec_access(input logic [1:0] s);
		return s == SEM_SECONDARY;
	endfunction

	// Next-state logic
	always_comb begin
		next_st = st;
		// Trap pin passes two flops
		next_st.trap_sync = {st.trap_sync[0], ext_trap};
		next_st.test_reset = 1'b0;
		// Semaphore writes; primary wins a same-cycle collision unless secondary owns
		if (primary_core_sem.wr && prim_may_write(st.sem)) begin
			next_st.sem = primary_core_sem.val;
		end else if (secondary_core_sem.wr && sec_may_write(st.sem)) begin
			next_st.sem = secondary_core_sem.val;
		end
		// Blocked writes fall through untouched
		case (st.run)
			IDLE: begin
				// Only the granted core may start, one at a time
				if (primary_core_start && prim_access(st.sem)) begin
					next_st.run = RUN;
					next_st.owner_sec = 1'b0;
					next_st.cyc = '0;
				end else if (secondary_core_start && sec_access(st.sem)) begin
					next_st.run = RUN;
					next_st.owner_sec = 1'b1;
					next_st.cyc = '0;
				end
			end
			RUN: begin
				// Cycle count only advances on divided ticks, so run length scales
				if (tick && st.cyc != MICRO_CYCLES) begin
					next_st.cyc = st.cyc + 16'h0001;
				end
				if (st.trap_sync[1]) begin
					next_st.status[ST_TRAP] = 1'b1;
					next_st.trap_p = 1'b1;
					next_st.trap_s = 1'b1;
					next_st.run = REENTER;
				end else if (result_valid && st.cyc == MICRO_CYCLES) begin
					// Results offered before the last tick are dropped on purpose
					next_st.runs = st.runs + 16'h0001;
					next_st.status[ST_PATTERN_DONE] = result.pattern_done;
					next_st.status[ST_SEQ_DONE] = result.seq_done;
					next_st.status[ST_SIG_FAIL] = st.status[ST_SIG_FAIL] | result.sig_fail;
					next_st.status[ST_INT_COMP_FAIL] = st.status[ST_INT_COMP_FAIL] | result.int_comp_fail;
					next_st.status[ST_TIMEOUT] = st.status[ST_TIMEOUT] | result.timeout;
					if (!result.seq_done && (st.runs + 16'h0001) >= run_budget) begin
						next_st.status[ST_OVERRUN] = 1'b1;
					end
					// Any failure traps both cores, not only the one under test
					if (result.sig_fail || result.int_comp_fail || result.timeout) begin
						next_st.trap_p = 1'b1;
						next_st.trap_s = 1'b1;
					end
					next_st.run = REENTER;
				end
			end
			REENTER: begin
				// Test reset returns the core to the fixed entry
				next_st.test_reset = 1'b1;
				next_st.reentry = REENTRY_ADDR;
				next_st.run = IDLE;
			end
			default: next_st.run = IDLE;
		endcase
		// Releasing the semaphore starts a fresh run count
		if (next_st.sem == SEM_RELEASED && st.sem != SEM_RELEASED) begin
			next_st.runs = '0;
		end
		// Decoded outputs follow the next state so they leave a flop
		next_st.grant_p = prim_access(next_st.sem);
		next_st.grant_s = sec_access(next_st.sem);
		next_st.busy = (next_st.run == RUN);
		next_st.hold_p = (next_st.run == RUN) && !next_st.owner_sec;
		next_st.hold_s = (next_st.run == RUN) && next_st.owner_sec;
	end

	// State register
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			st <= '0;
			st.sem <= SEM_RESET;
			st.run <= IDLE;
			st.status <= STATUS_RESET;
			st.reentry <= REENTRY_ADDR;
			st.grant_p <= 1'b1; // Primary may use the controller at zero
		end else begin
			st <= next_st;
		end
	end

	// Outputs straight from flops
	assign sem_state = st.sem;
	assign primary_core_grant = st.grant_p;
	assign secondary_core_grant = st.grant_s;
	assign micro_busy = st.busy;
	assign primary_core_hold = st.hold_p;
	assign secondary_core_hold = st.hold_s;
	assign test_reset = st.test_reset;
	assign reentry_addr = st.reentry;
	assign status = st.status;
	assign primary_core_trap = st.trap_p;
	assign secondary_core_trap = st.trap_s;

	// Clean end of a micro-run, shared by the result checks
	logic result_taken;
	assign result_taken = (st.run == RUN) && result_valid && (st.cyc == MICRO_CYCLES) && !st.trap_sync[1];

	// Assertions
	// Reset leaves the semaphore at zero
	a_sem_reset_zero: assert property (@(posedge mclk) $rose(rst_b) |-> sem_state == SEM_RESET)
		else $error("semaphore not zero after reset");
	// A write from the blocked core leaves the code alone
	a_blocked_sec_ign: assert property (@(posedge mclk) disable iff (!rst_b)
		(sem_state == SEM_PRIMARY && secondary_core_sem.wr && !primary_core_sem.wr) |=> sem_state == SEM_PRIMARY)
		else $error("blocked secondary write changed semaphore");
	a_blocked_prim_ign: assert property (@(posedge mclk) disable iff (!rst_b)
		(sem_state == SEM_SECONDARY && primary_core_sem.wr && !secondary_core_sem.wr) |=> sem_state == SEM_SECONDARY)
		else $error("blocked primary write changed semaphore");
	// Claims from zero grant the writer alone
	a_prim_claim: assert property (@(posedge mclk) disable iff (!rst_b)
		(sem_state == SEM_RESET && primary_core_sem.wr && primary_core_sem.val == SEM_PRIMARY)
		|=> primary_core_grant && !secondary_core_grant)
		else $error("primary claim not granted");
	a_sec_claim: assert property (@(posedge mclk) disable iff (!rst_b)
		(sem_state == SEM_RESET && secondary_core_sem.wr && !primary_core_sem.wr
		&& secondary_core_sem.val == SEM_SECONDARY) |=> secondary_core_grant && !primary_core_grant)
		else $error("secondary claim not granted");
	a_grant_zero: assert property (@(posedge mclk) disable iff (!rst_b)
		sem_state == SEM_RESET |-> primary_core_grant && !secondary_core_grant)
		else $error("primary not granted at zero");
	// Released code is open to either core
	a_release_any: assert property (@(posedge mclk) disable iff (!rst_b)
		(sem_state == SEM_RELEASED && secondary_core_sem.wr && !primary_core_sem.wr)
		|=> sem_state == $past(secondary_core_sem.val))
		else $error("released semaphore not writable");
	// Never two owners and never two frozen cores
	a_grant_excl: assert property (@(posedge mclk) disable iff (!rst_b)
		!(primary_core_grant && secondary_core_grant))
		else $error("both cores granted");
	a_one_hold: assert property (@(posedge mclk) disable iff (!rst_b)
		!(primary_core_hold && secondary_core_hold))
		else $error("both cores held");
	a_busy_hold: assert property (@(posedge mclk) disable iff (!rst_b)
		micro_busy |-> (primary_core_hold != secondary_core_hold))
		else $error("run without exactly one frozen core");
	// Failure traps reach both cores and stop the run
	a_trap_both: assert property (@(posedge mclk) disable iff (!rst_b)
		$rose(status[ST_TRAP]) |-> primary_core_trap && secondary_core_trap)
		else $error("trap not delivered to both cores");
	a_trap_stops: assert property (@(posedge mclk) disable iff (!rst_b)
		(micro_busy && st.trap_sync[1]) |=> !micro_busy ##1 test_reset)
		else $error("trap did not stop micro-run");
	// Re-entry is a one-cycle pulse at the fixed address
	a_reentry_zero: assert property (@(posedge mclk) disable iff (!rst_b)
		test_reset |-> reentry_addr == REENTRY_ADDR)
		else $error("re-entry address wrong");
	a_reset_pulse: assert property (@(posedge mclk) disable iff (!rst_b)
		test_reset |=> !test_reset)
		else $error("test reset longer than one cycle");
	// Run length scales with the divider
	a_half_len: assert property (@(posedge mclk) disable iff (!rst_b)
		(micro_busy && test_clock_divider_config[DIV_MSB:DIV_LSB] == DIV_HALF && $stable(st.cyc)
		&& st.cyc != MICRO_CYCLES) |=> $changed(st.cyc) || !micro_busy)
		else $error("half rate count stalled");
	a_early_drop: assert property (@(posedge mclk) disable iff (!rst_b)
		(micro_busy && result_valid && st.cyc != MICRO_CYCLES && !st.trap_sync[1]) |=> micro_busy)
		else $error("early result ended the run");
	// Result flags land in the status word
	a_pass_flags: assert property (@(posedge mclk) disable iff (!rst_b)
		result_taken |=> status[ST_PATTERN_DONE] == $past(result.pattern_done)
		&& status[ST_SEQ_DONE] == $past(result.seq_done))
		else $error("completion flags not taken from result");
	a_sig_trap: assert property (@(posedge mclk) disable iff (!rst_b)
		(result_taken && result.sig_fail) |=> status[ST_SIG_FAIL] && primary_core_trap && secondary_core_trap)
		else $error("signature failure not flagged");
	a_overrun_flag: assert property (@(posedge mclk) disable iff (!rst_b)
		(result_taken && !result.seq_done && st.runs >= run_budget - 16'h0001) |=> status[ST_OVERRUN])
		else $error("overrun not flagged");

	// Covers
	c_prim_run: cover property (@(posedge mclk) primary_core_hold ##[1:1000] test_reset);
	c_sec_run: cover property (@(posedge mclk) secondary_core_hold ##[1:1000] test_reset);
	c_trap: cover property (@(posedge mclk) $rose(primary_core_trap));
	c_pass: cover property (@(posedge mclk) status[ST_PATTERN_DONE] && status[ST_SEQ_DONE]);
	c_overrun: cover property (@(posedge mclk) $rose(status[ST_OVERRUN]));

endmodule

/* File: design/csta_pkg.sv */
package csta_pkg;

	// Ownership semaphore codes
	localparam logic [1:0] SEM_RESET = 2'h0;
	localparam logic [1:0] SEM_SECONDARY = 2'h1;
	localparam logic [1:0] SEM_PRIMARY = 2'h2;
	localparam logic [1:0] SEM_RELEASED = 2'h3;

	// Clock divider field inside the test clock configuration word
	localparam int DIV_LSB = 18;
	localparam int DIV_MSB = 19;
	localparam logic [1:0] DIV_FULL = 2'h0;
	localparam logic [1:0] DIV_HALF = 2'h1;
	localparam logic [1:0] DIV_QUARTER = 2'h2;

	// Re-entry address and reserved block size after a test reset
	localparam logic [15:0] REENTRY_ADDR = 16'h0000;
	localparam logic [15:0] REENTRY_WORDS = 16'h0020;

	// Status word bit positions
	localparam int ST_PATTERN_DONE = 0;
	localparam int ST_SEQ_DONE = 1;
	localparam int ST_TRAP = 2;
	localparam int ST_SIG_FAIL = 3;
	localparam int ST_INT_COMP_FAIL = 4;
	localparam int ST_TIMEOUT = 5;
	localparam int ST_OVERRUN = 6;
	localparam logic [7:0] STATUS_RESET = 8'h00;

	// Default micro-run budget and micro-run length
	localparam logic [15:0] RUN_BUDGET_RESET = 16'h02EE;
	localparam logic [15:0] MICRO_CYCLES = 16'h0100;

	// Semaphore write request from one core
	typedef struct packed {
		logic wr;
		logic [1:0] val;
	} csta_sem_req_t;

	// Pass and fail results reported by the scan engine at the end of a micro-run
	typedef struct packed {
		logic pattern_done;
		logic seq_done;
		logic sig_fail;
		logic int_comp_fail;
		logic timeout;
	} csta_result_t;

endpackage

/* File: design/csta_clk_div.sv */
`timescale 1ns/1ps
// Test clock enable generator: full, half or quarter rate
module csta_clk_div import csta_pkg::*; (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_b,
	// Divider selection
	input wire logic [1:0] div_sel,
	// Enable pulse for the scan engine
	output logic tick
);

	// All state in one struct
	typedef struct packed {
		logic [1:0] cnt;
		logic tick;
	} csta_div_state_t;

	csta_div_state_t st;
	csta_div_state_t next_st;

	// Tick every 1, 2 or 4 cycles
	always_comb begin
		next_st = st;
		next_st.cnt = st.cnt + 2'h1;
		case (div_sel)
			DIV_HALF: next_st.tick = st.cnt[0];
			DIV_QUARTER: next_st.tick = (st.cnt == 2'h3);
			default: next_st.tick = 1'b1;
		endcase
	end

	// State register
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign tick = st.tick;

endmodule

/* File: tb/csta_core_model.sv */
`timescale 1ns/1ps
// Two cores and the scan engine's answer
module csta_core_model import csta_pkg::*; (
	// Clock
	input wire logic mclk,
	// Run state and answer enable
	input wire logic micro_busy,
	input wire logic answer_en,
	// Core requests
	output csta_sem_req_t primary_core_sem,
	output csta_sem_req_t secondary_core_sem,
	output logic primary_core_start,
	output logic secondary_core_start,
	// Engine strobe
	output logic result_valid
);
	// Reserved context-save region, largest configuration
	localparam int CTX_WORDS = 82;
	logic [15:0] ctx_save [CTX_WORDS];
	// Both cores keep their vector expander on so either can take the trap
	logic [1:0] vector_expander_enable;
	// Quiet at time zero
	initial begin
		vector_expander_enable = 2'h3;
		primary_core_sem = '0;
		secondary_core_sem = '0;
		primary_core_start = 1'b0;
		secondary_core_start = 1'b0;
	end
	// Engine offers a result on every run cycle while answer_en is set; early ones must be dropped
	always @(negedge mclk) begin
		result_valid <= micro_busy & answer_en;
	end
	// One-cycle semaphore write
	task sem_wr(input bit sec, input logic [1:0] v);
		@(negedge mclk);
		if (sec) secondary_core_sem = '{wr: 1'b1, val: v};
		else primary_core_sem = '{wr: 1'b1, val: v};
		@(negedge mclk);
		primary_core_sem = '0;
		secondary_core_sem = '0;
	endtask
	// Start held until the run shows, bounded
	task start(input bit sec, output bit seen);
		seen = 1'b0;
		// Full context lands in the reserved stack region before the run
		for (int i = 0; i < CTX_WORDS; i++) begin
			ctx_save[i] = 16'(i);
		end
		@(negedge mclk);
		if (sec) secondary_core_start = 1'b1;
		else primary_core_start = 1'b1;
		for (int i = 0; i < 8 && !seen; i++) begin
			@(negedge mclk);
			seen = (micro_busy === 1'b1);
		end
		primary_core_start = 1'b0;
		secondary_core_start = 1'b0;
	endtask
endmodule

/* File: tb/tb_csta_top.sv */
`timescale 1ns/1ps
// Bench for the shared self-test controller
module tb_csta_top import csta_pkg::*; ;
	logic mclk;
	logic rst_b;
	logic [31:0] cfg;
	logic [15:0] budget;
	csta_result_t res;
	logic ext_trap;
	logic answer_en;
	csta_sem_req_t psem;
	csta_sem_req_t ssem;
	logic pstart;
	logic sstart;
	logic rv;
	logic [1:0] sem;
	logic pg;
	logic sg;
	logic busy;
	logic ph;
	logic sh;
	logic tr;
	logic [15:0] raddr;
	logic [7:0] status;
	logic pt;
	logic st;
	int n_mismatch = 0;
	int checks_done = 0;
	bit ok;
	int n;
	// Free-running clock, 4 ns
	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end
	csta_core_model m (.mclk(mclk), .micro_busy(busy), .answer_en(answer_en),
		.primary_core_sem(psem), .secondary_core_sem(ssem), .primary_core_start(pstart),
		.secondary_core_start(sstart), .result_valid(rv));
	csta_top uut (.mclk(mclk), .rst_b(rst_b), .primary_core_sem(psem), .secondary_core_sem(ssem),
		.primary_core_start(pstart), .secondary_core_start(sstart), .test_clock_divider_config(cfg),
		.run_budget(budget), .result_valid(rv), .result(res), .ext_trap(ext_trap), .sem_state(sem),
		.primary_core_grant(pg), .secondary_core_grant(sg), .micro_busy(busy), .primary_core_hold(ph),
		.secondary_core_hold(sh), .test_reset(tr), .reentry_addr(raddr), .status(status),
		.primary_core_trap(pt), .secondary_core_trap(st));
	// Compare and count
	task check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: saw %0h want %0h", $time, seen, exp);
		end
	endtask
	// Verdict and end of run
	task conclude();
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	// Count busy cycles, then look for the test reset pulse
	task finish_run();
		n = 0;
		while (busy === 1'b1 && n < 3000) begin
			@(negedge mclk);
			n++;
		end
		check(n < 3000, 1);
		ok = 1'b0;
		for (int i = 0; i < 4 && !ok; i++) begin
			@(negedge mclk);
			ok = (tr === 1'b1);
		end
		check(ok, 1);
	endtask
	// Main sequence
	initial begin
		rst_b = 1'b0;
		cfg = 32'h0;
		budget = 16'h0010;
		res = '0;
		ext_trap = 1'b0;
		answer_en = 1'b1;
		repeat (8) @(negedge mclk);
		rst_b = 1'b1;
		check(sem, SEM_RESET);
		check({pg, sg}, 2'h2);
		check(raddr, REENTRY_ADDR);
		check({status, pt, st}, 10'h0);
		$display("reset test ended");
		// Claim, blocked writes, release
		m.sem_wr(1, SEM_SECONDARY);
		check({sem, pg, sg}, 4'h5);
		m.sem_wr(0, SEM_PRIMARY);
		check(sem, SEM_SECONDARY);
		m.sem_wr(1, SEM_RELEASED);
		check(sem, SEM_RELEASED);
		m.sem_wr(0, SEM_PRIMARY);
		m.sem_wr(1, SEM_SECONDARY);
		check({sem, pg, sg}, 4'hA);
		$display("ownership test ended");
		// Passing runs at every divider setting; owner holds the semaphore
		res.pattern_done = 1'b1;
		res.seq_done = 1'b1;
		for (int d = 0; d < 3; d++) begin
			cfg[DIV_MSB:DIV_LSB] = d[1:0];
			m.start(0, ok);
			check(ok, 1);
			check({ph, sh}, 2'h2);
			finish_run();
			check(n >= (256 << d) - 2 && n <= (256 << d) + 8, 1);
			check(status[6:0], 7'h03);
		end
		m.start(1, ok);
		check(ok, 0);
		$display("run test ended");
		// Failing run past the budget
		budget = 16'h0001;
		res.seq_done = 1'b0;
		res.sig_fail = 1'b1;
		m.start(0, ok);
		check(ok, 1);
		finish_run();
		check(status[ST_SIG_FAIL], 1);
		check(status[ST_OVERRUN], 1);
		check({pt, st}, 2'h3);
		// Trap in mid-run
		answer_en = 1'b0;
		m.start(0, ok);
		check(ok, 1);
		repeat (20) @(negedge mclk);
		ext_trap = 1'b1;
		finish_run();
		ext_trap = 1'b0;
		check(n <= 5, 1);
		check(status[ST_TRAP], 1);
		check({pt, st} & m.vector_expander_enable, 2'h3);
		m.sem_wr(0, SEM_RELEASED);
		check(sem, SEM_RELEASED);
		$display("failure test ended");
		// Secondary takes the released controller and runs cleanly
		answer_en = 1'b1;
		res = '0;
		res.pattern_done = 1'b1;
		res.seq_done = 1'b1;
		m.sem_wr(1, SEM_SECONDARY);
		check({sem, pg, sg}, 4'h5);
		m.start(1, ok);
		check(ok, 1);
		check({ph, sh}, 2'h1);
		finish_run();
		check(n >= 1022 && n <= 1032, 1);
		check(status[1:0], 2'h3);
		check(m.ctx_save[81], 16'h0051);
		m.sem_wr(1, SEM_RELEASED);
		check(sem, SEM_RELEASED);
		$display("secondary test ended");
		// Second reset clears ownership and traps; primary then claims from zero
		@(negedge mclk);
		rst_b = 1'b0;
		@(negedge mclk);
		check({sem, pg, pt, st}, 5'h04);
		rst_b = 1'b1;
		m.sem_wr(0, SEM_PRIMARY);
		check({sem, pg, sg}, 4'hA);
		$display("second reset test ended");
		conclude();
	end
endmodule
